// >>> flash_status_pkg.sv
package flash_status_pkg;
	// status commands carried on the serial link
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_VOL_WRITE_ENABLE = 8'h50;
	localparam logic [7:0] CMD_WRITE_FIRST = 8'h01;
	localparam logic [7:0] CMD_WRITE_SECOND = 8'h31;
	localparam logic [7:0] CMD_WRITE_THIRD = 8'h11;
	localparam logic [7:0] CMD_READ_FIRST = 8'h05;
	localparam logic [7:0] CMD_READ_SECOND = 8'h35;
	localparam logic [7:0] CMD_READ_THIRD = 8'h15;
	// field positions, first register
	localparam int BIT_BUSY = 0;
	localparam int BIT_LATCH = 1;
	localparam int GUARD_LSB = 2;
	localparam int BIT_LOW_END = 5;
	localparam int BIT_GRANULE = 6;
	localparam int BIT_MODE_LO = 7;
	// field positions, second register
	localparam int BIT_MODE_HI = 0;
	localparam int BIT_QUAD = 1;
	localparam int LOCK_LSB = 3;
	localparam int BIT_INVERT = 6;
	localparam int BIT_PAUSED = 7;
	// field positions, third register
	localparam int BIT_FAST = 4;
	localparam int DRIVE_LSB = 5;
	localparam int BIT_PIN_SEL = 7;
	// writable bits of each copy
	localparam logic [7:0] MASK_FIRST = 8'hFC;
	localparam logic [7:0] MASK_SECOND = 8'h43;
	localparam logic [7:0] MASK_OTP = 8'h38;
	localparam logic [7:0] MASK_THIRD_VOL = 8'hF0;
	localparam logic [7:0] MASK_THIRD_NV = 8'h90;
	// reset values
	localparam logic [7:0] RESET_FIRST = 8'h00;
	localparam logic [7:0] RESET_SECOND = 8'h00;
	localparam logic [7:0] RESET_THIRD = 8'h00;
	// timing: non-volatile status write time
	localparam int CLK_PERIOD_PS = 4000;
	localparam int T_STATUS_WRITE_NS = 4000;
	localparam int WRITE_CYCLES = (T_STATUS_WRITE_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [11:0] WRITE_LAST = 12'(WRITE_CYCLES - 1);
	// busy sequencer states
	typedef enum logic [2:0] {
		ST_READY = 3'b001,
		ST_STATUS_WRITE = 3'b010,
		ST_ARRAY_OP = 3'b100
	} seq_state_type;
endpackage

// >>> flash_status_regs.sv
`timescale 1ns/1ps
// Functional notes
// RL1: top bit of second: suspended flag
// RL2: second bit 6 inverts protection map
// RL3: second bits 5..3 one-time lock flags
// RL4: quad enable frees guard and pause pins
// RL5: second bit 0 upper protect mode
// RL6: third bit 7 picks pause or reset
// RL7: third bits 6..5 volatile drive strength
// RL8: third bit 4 high frequency mode
// RL9: busy high during program, erase, write
// RL10: while busy only status reads accepted
// RL11: busy drops when operation completes
// RL12: write enable sets write latch
// RL13: latch clears on reset, disable, completion
// RL14: first bits 4..2 block guard, writable
// RL15: first bit 5 protects from low end
// RL16: direction bit written only when permitted
// RL17: first bit 6 selects sector granularity
// RL18: invert flag complements protection map
// RL19: reset loads volatile from non-volatile copies
// RL20: 06h targets non-volatile, 50h volatile
// RL21: status writes never touch status flags
// RL22: hardware protect with guard low rejects
// RL23: reserved bits read zero, writes ignored
module flash_status_regs (
	// clock, reset, enable
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	// serial link pins
	input wire logic SPI_SCK,
	input wire logic SPI_CS_N,
	input wire logic SPI_MOSI,
	output logic SPI_MISO,
	output logic SPI_MISO_OE,
	input wire logic WRITE_GUARD_N,
	// array engine handshake
	input wire logic OP_START,
	input wire logic OP_DONE,
	input wire logic SUSPEND_REQ,
	input wire logic RESUME_REQ,
	input wire logic SOFT_RESET,
	// status outputs
	output logic BUSY,
	output logic WRITE_LATCH_OPEN,
	output logic PAUSED_OPERATION_FLAG,
	// protection outputs
	output logic [2:0] BLOCK_GUARD,
	output logic PROTECT_FROM_LOW_END,
	output logic GRANULE_SIZE_SELECT,
	output logic INVERT_PROTECT_MAP,
	output logic [2:0] OTP_LOCK,
	// pin function and drive outputs
	output logic QUAD_IO_ENABLE,
	output logic WRITE_GUARD_ACTIVE,
	output logic PAUSE_PIN_ACTIVE,
	output logic RESET_PIN_ACTIVE,
	output logic [1:0] DRIVE_LEVEL,
	output logic FAST_READ_PRECHARGE_ENABLE
);
	logic [2:0] sck_sync; // link clock synchroniser and edge stage
	logic [2:0] cs_sync; // select synchroniser and edge stage
	logic [1:0] mosi_sync; // data in synchroniser
	logic [1:0] wp_sync; // guard pin synchroniser
	logic [7:0] shift_in; // incoming byte
	logic [2:0] bit_cnt; // bits of the current byte
	logic [1:0] byte_cnt; // whole bytes, saturates at 3
	logic [7:0] cmd; // first byte of the frame
	logic [7:0] data1; // second byte
	logic [7:0] data2; // third byte
	logic [7:0] nv1, nv2, nv3; // non-volatile copies
	logic [7:0] vol1, vol2, vol3; // volatile (active) copies
	logic latch_open; // write latch, 06h
	logic vol_wen; // volatile write enable, 50h
	logic paused; // suspend flag
	logic [11:0] wcount; // status write timer
	flash_status_pkg::seq_state_type state;
	logic sck_rise, sck_fall, cs_rise, cs_low;
	logic exec, run, busy_now, locked, is_write, wr_go;
	logic [7:0] read_byte; // image of the register being read

	// merge written bits into a copy under a mask
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] mask);
		merge = (old & ~mask) | (nw & mask);
	endfunction

	// reads are the only commands served while busy
	function automatic logic is_read(input logic [7:0] c);
		is_read = (c == flash_status_pkg::CMD_READ_FIRST) ||
			(c == flash_status_pkg::CMD_READ_SECOND) ||
			(c == flash_status_pkg::CMD_READ_THIRD);
	endfunction

	// register image as the host sees it; status bits overlaid
	function automatic logic [7:0] read_value(input logic [7:0] c);
		logic [7:0] r;
		r = 8'h00;
		case (c)
			flash_status_pkg::CMD_READ_FIRST: begin
				r = vol1 & flash_status_pkg::MASK_FIRST;
				r[flash_status_pkg::BIT_BUSY] = busy_now; // RL9 RL21
				r[flash_status_pkg::BIT_LATCH] = latch_open; // RL12 RL21
			end
			flash_status_pkg::CMD_READ_SECOND: begin
				r = (vol2 & flash_status_pkg::MASK_SECOND) | (nv2 & flash_status_pkg::MASK_OTP); // RL23
				r[flash_status_pkg::BIT_PAUSED] = paused; // RL1
			end
			flash_status_pkg::CMD_READ_THIRD: begin
				r = vol3 & flash_status_pkg::MASK_THIRD_VOL; // RL23
			end
			default: begin
				r = 8'h00;
			end
		endcase
		read_value = r;
	endfunction

	// pins cross into REF_CLK through two flops before use
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sck_sync <= 3'h0;
			cs_sync <= 3'h7;
			mosi_sync <= 2'h0;
			wp_sync <= 2'h3;
		end else if (CLK_EN) begin
			sck_sync <= {sck_sync[1:0], SPI_SCK};
			cs_sync <= {cs_sync[1:0], SPI_CS_N};
			mosi_sync <= {mosi_sync[0], SPI_MOSI};
			wp_sync <= {wp_sync[0], WRITE_GUARD_N};
		end
	end

	// edges are found only on the second and third stages
	assign sck_rise = sck_sync[1] & ~sck_sync[2];
	assign sck_fall = ~sck_sync[1] & sck_sync[2];
	assign cs_rise = cs_sync[1] & ~cs_sync[2];
	assign cs_low = ~cs_sync[1];
	assign busy_now = (state != flash_status_pkg::ST_READY);
	// commands act only on a byte boundary at deselect
	assign exec = cs_rise && (bit_cnt == 3'h0) && (byte_cnt != 2'h0);
	assign run = exec && !busy_now; // RL10
	// hardware lock when guard pin is in use, supply or otp lock
	assign locked = vol2[flash_status_pkg::BIT_MODE_HI] ||
		(vol1[flash_status_pkg::BIT_MODE_LO] && !wp_sync[1] &&
		!vol2[flash_status_pkg::BIT_QUAD]); // RL22 RL5
	assign is_write = (byte_cnt >= 2'h2) && (
		cmd == flash_status_pkg::CMD_WRITE_THIRD ||
		((cmd == flash_status_pkg::CMD_WRITE_FIRST ||
		cmd == flash_status_pkg::CMD_WRITE_SECOND) && !locked)); // RL16 RL22
	assign wr_go = run && is_write && (latch_open || vol_wen); // RL20

	// frame receiver: mode 0, sampled on the rising link edge
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			shift_in <= 8'h00;
			bit_cnt <= 3'h0;
			byte_cnt <= 2'h0;
			cmd <= 8'h00;
			data1 <= 8'h00;
			data2 <= 8'h00;
		end else if (CLK_EN) begin
			if (!cs_low) begin
				// idle between frames
				bit_cnt <= 3'h0;
				byte_cnt <= 2'h0;
			end else if (sck_rise) begin
				shift_in <= {shift_in[6:0], mosi_sync[1]};
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					if (byte_cnt != 2'h3) begin
						byte_cnt <= byte_cnt + 2'h1;
					end
					case (byte_cnt)
						2'h0: cmd <= {shift_in[6:0], mosi_sync[1]};
						2'h1: data1 <= {shift_in[6:0], mosi_sync[1]};
						2'h2: data2 <= {shift_in[6:0], mosi_sync[1]};
						default: data2 <= data2;
					endcase
				end
			end
		end
	end

	// image rebuilt every cycle; a process, so the flags read inside the function wake it
	always_comb begin
		read_byte = read_value(cmd);
	end

	// read data shifted out on the falling link edge, msb first
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			SPI_MISO <= 1'b0;
			SPI_MISO_OE <= 1'b0;
		end else if (CLK_EN) begin
			if (!cs_low) begin
				SPI_MISO_OE <= 1'b0;
			end else if (sck_fall && byte_cnt != 2'h0 && is_read(cmd)) begin
				// the register is re-read every byte, so polling busy works
				SPI_MISO <= read_byte[3'h7 - bit_cnt];
				SPI_MISO_OE <= 1'b1;
			end
		end
	end

	// busy sequencer for status writes and array operations
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state <= flash_status_pkg::ST_READY;
			wcount <= 12'h000;
			paused <= 1'b0;
		end else if (CLK_EN) begin
			if (RESUME_REQ && paused && !busy_now) begin
				paused <= 1'b0;
			end
			if (SUSPEND_REQ && state == flash_status_pkg::ST_ARRAY_OP) begin
				paused <= 1'b1; // RL1
			end
			case (state)
				flash_status_pkg::ST_READY: begin
					if (wr_go && latch_open) begin
						state <= flash_status_pkg::ST_STATUS_WRITE; // RL9
						wcount <= flash_status_pkg::WRITE_LAST;
					end else if (OP_START && latch_open && !paused) begin
						state <= flash_status_pkg::ST_ARRAY_OP; // RL9
					end else if (RESUME_REQ && paused) begin
						state <= flash_status_pkg::ST_ARRAY_OP;
					end
				end
				flash_status_pkg::ST_STATUS_WRITE: begin
					if (wcount == 12'h000) begin
						state <= flash_status_pkg::ST_READY; // RL11
					end else begin
						wcount <= wcount - 12'h001;
					end
				end
				flash_status_pkg::ST_ARRAY_OP: begin
					// a suspend frees the bus but keeps the flag up
					if (OP_DONE || SUSPEND_REQ) begin
						state <= flash_status_pkg::ST_READY; // RL11
					end
				end
				default: begin
					state <= flash_status_pkg::ST_READY;
				end
			endcase
		end
	end

	// write latch and volatile enable; a set beats a clear
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			latch_open <= 1'b0; // RL13
			vol_wen <= 1'b0;
		end else if (CLK_EN) begin
			if (SOFT_RESET || (run && cmd == flash_status_pkg::CMD_WRITE_DISABLE) ||
				(state == flash_status_pkg::ST_STATUS_WRITE && wcount == 12'h000) ||
				(state == flash_status_pkg::ST_ARRAY_OP && OP_DONE)) begin
				latch_open <= 1'b0; // RL13
			end
			if (wr_go || SOFT_RESET) begin
				vol_wen <= 1'b0;
			end
			if (run && cmd == flash_status_pkg::CMD_WRITE_ENABLE) begin
				latch_open <= 1'b1; // RL12
				vol_wen <= 1'b0;
			end
			if (run && cmd == flash_status_pkg::CMD_VOL_WRITE_ENABLE) begin
				vol_wen <= 1'b1; // RL20
			end
		end
	end

	// configuration copies; status flags are never written here
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			nv1 <= flash_status_pkg::RESET_FIRST; // RL14 RL15 RL17
			nv2 <= flash_status_pkg::RESET_SECOND; // RL2 RL3
			nv3 <= flash_status_pkg::RESET_THIRD; // RL8
			vol1 <= flash_status_pkg::RESET_FIRST;
			vol2 <= flash_status_pkg::RESET_SECOND;
			vol3 <= flash_status_pkg::RESET_THIRD; // RL7
		end else if (CLK_EN) begin
			if (SOFT_RESET) begin
				// supply lock-down is released by a reset
				vol1 <= nv1; // RL19
				vol2 <= nv2; // RL19
				vol3 <= merge(flash_status_pkg::RESET_THIRD, nv3,
					flash_status_pkg::MASK_THIRD_NV); // RL19
				if (nv2[flash_status_pkg::BIT_MODE_HI] && !nv1[flash_status_pkg::BIT_MODE_LO]) begin
					nv2[flash_status_pkg::BIT_MODE_HI] <= 1'b0;
					vol2[flash_status_pkg::BIT_MODE_HI] <= 1'b0;
				end
			end else if (wr_go) begin
				case (cmd)
					flash_status_pkg::CMD_WRITE_FIRST: begin
						vol1 <= merge(vol1, data1, flash_status_pkg::MASK_FIRST); // RL14 RL15
						if (latch_open) begin
							nv1 <= merge(nv1, data1, flash_status_pkg::MASK_FIRST); // RL20
						end
						if (byte_cnt == 2'h3) begin
							vol2 <= merge(vol2, data2, flash_status_pkg::MASK_SECOND);
							if (latch_open) begin
								nv2 <= merge(nv2, data2, flash_status_pkg::MASK_SECOND) |
									(data2 & flash_status_pkg::MASK_OTP); // RL3
							end
						end
					end
					flash_status_pkg::CMD_WRITE_SECOND: begin
						vol2 <= merge(vol2, data1, flash_status_pkg::MASK_SECOND); // RL23
						if (latch_open) begin
							// lock flags only ever go from 0 to 1
							nv2 <= merge(nv2, data1, flash_status_pkg::MASK_SECOND) |
								(data1 & flash_status_pkg::MASK_OTP); // RL3
						end
					end
					default: begin
						// third register: drive strength has no stored copy
						vol3 <= merge(vol3, data1, flash_status_pkg::MASK_THIRD_VOL); // RL7
						if (latch_open) begin
							nv3 <= merge(nv3, data1, flash_status_pkg::MASK_THIRD_NV); // RL8
						end
					end
				endcase
			end
		end
	end

	// registered outputs, one cycle behind the internal state
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			BUSY <= 1'b0;
			WRITE_LATCH_OPEN <= 1'b0;
			PAUSED_OPERATION_FLAG <= 1'b0;
			BLOCK_GUARD <= 3'h0;
			PROTECT_FROM_LOW_END <= 1'b0;
			GRANULE_SIZE_SELECT <= 1'b0;
			INVERT_PROTECT_MAP <= 1'b0;
			OTP_LOCK <= 3'h0;
			QUAD_IO_ENABLE <= 1'b0;
			WRITE_GUARD_ACTIVE <= 1'b1;
			PAUSE_PIN_ACTIVE <= 1'b1;
			RESET_PIN_ACTIVE <= 1'b0;
			DRIVE_LEVEL <= 2'h0;
			FAST_READ_PRECHARGE_ENABLE <= 1'b0;
		end else if (CLK_EN) begin
			BUSY <= busy_now; // RL9
			WRITE_LATCH_OPEN <= latch_open;
			PAUSED_OPERATION_FLAG <= paused; // RL1
			BLOCK_GUARD <= vol1[flash_status_pkg::GUARD_LSB +: 3]; // RL14
			PROTECT_FROM_LOW_END <= vol1[flash_status_pkg::BIT_LOW_END]; // RL15
			GRANULE_SIZE_SELECT <= vol1[flash_status_pkg::BIT_GRANULE]; // RL17
			INVERT_PROTECT_MAP <= vol2[flash_status_pkg::BIT_INVERT]; // RL2 RL18
			OTP_LOCK <= nv2[flash_status_pkg::LOCK_LSB +: 3]; // RL3
			QUAD_IO_ENABLE <= vol2[flash_status_pkg::BIT_QUAD]; // RL4
			WRITE_GUARD_ACTIVE <= !vol2[flash_status_pkg::BIT_QUAD]; // RL4
			PAUSE_PIN_ACTIVE <= !vol2[flash_status_pkg::BIT_QUAD] &&
				!vol3[flash_status_pkg::BIT_PIN_SEL]; // RL6
			RESET_PIN_ACTIVE <= !vol2[flash_status_pkg::BIT_QUAD] &&
				vol3[flash_status_pkg::BIT_PIN_SEL]; // RL6
			DRIVE_LEVEL <= vol3[flash_status_pkg::DRIVE_LSB +: 2]; // RL7
			FAST_READ_PRECHARGE_ENABLE <= vol3[flash_status_pkg::BIT_FAST]; // RL8
		end
	end

	// checks: enable held high across each window they watch
	property p_busy_write;
		@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
		state == flash_status_pkg::ST_STATUS_WRITE |=> BUSY;
	endproperty
	a_busy_write: assert property (p_busy_write) else $error("busy low in status write"); // RL9
	property p_busy_end;
		@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
		(state == flash_status_pkg::ST_STATUS_WRITE && wcount == 12'h000) |=> ##1 !BUSY;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy stuck after write"); // RL11
	property p_ignore_busy;
		@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
		(exec && busy_now && !SOFT_RESET) |=> $stable(nv1) && $stable(vol1) && $stable(vol3);
	endproperty
	a_ignore_busy: assert property (p_ignore_busy) else $error("command taken while busy"); // RL10
	property p_latch_set;
		@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
		(run && cmd == flash_status_pkg::CMD_WRITE_ENABLE) |=> ##1 WRITE_LATCH_OPEN;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("write enable lost"); // RL12
	property p_latch_clear;
		@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
		(run && cmd == flash_status_pkg::CMD_WRITE_DISABLE) |=> !latch_open ##1 !WRITE_LATCH_OPEN;
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("write disable ignored"); // RL13
	property p_flags_kept;
		@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
		(wr_go && !SUSPEND_REQ && !RESUME_REQ) |=> $stable(paused);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("status write moved flag"); // RL21
	property p_guard_lock;
		@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
		(exec && locked && !SOFT_RESET && cmd != flash_status_pkg::CMD_WRITE_THIRD)
			|=> $stable(vol1) && $stable(vol2);
	endproperty
	a_guard_lock: assert property (p_guard_lock) else $error("locked register written"); // RL22
	property p_otp_sticky;
		@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
		##1 ($past(nv2[5:3]) & ~nv2[5:3]) == 3'h0;
	endproperty
	a_otp_sticky: assert property (p_otp_sticky) else $error("lock flag cleared"); // RL3
	property p_reload;
		@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
		SOFT_RESET |=> vol1 == $past(nv1);
	endproperty
	a_reload: assert property (p_reload) else $error("volatile copy not reloaded"); // RL19
	property p_pin_exclusive;
		@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
		QUAD_IO_ENABLE |-> !(PAUSE_PIN_ACTIVE || RESET_PIN_ACTIVE || WRITE_GUARD_ACTIVE);
	endproperty
	a_pin_exclusive: assert property (p_pin_exclusive) else $error("pin function with quad"); // RL4
	c_nv_write: cover property (@(posedge REF_CLK) wr_go && latch_open);
	c_vol_write: cover property (@(posedge REF_CLK) wr_go && !latch_open);
	c_suspend: cover property (@(posedge REF_CLK) paused && !busy_now);
	c_read_busy: cover property (@(posedge REF_CLK) SPI_MISO_OE && busy_now);
endmodule

// >>> spi_host.sv
`timescale 1ns/1ps
// behavioural link master, mode 0, 48 ns link clock period
module spi_host (
	// link pins
	output logic SCK,
	output logic CS_N,
	output logic MOSI,
	input wire logic MISO
);
	// link idles low, select released
	initial begin
		SCK = 1'b0;
		CS_N = 1'b1;
		MOSI = 1'b0;
	end
	// sends nb bytes msb first from the top of tx; rx keeps the last byte seen
	task automatic xfer(input logic [23:0] tx, input int nb, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		#3;
		CS_N = 1'b0;
		#24;
		for (i = 23; i >= 24 - 8 * nb; i--) begin
			MOSI = tx[i];
			#24;
			SCK = 1'b1;
			rx = {rx[6:0], MISO};
			#24;
			SCK = 1'b0;
		end
		#24;
		CS_N = 1'b1;
		// released data line must not look like held data
		MOSI = ~MOSI;
		// gap long enough for the synced select rise to act
		#96;
	endtask
endmodule

// >>> flash_status_regs_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module flash_status_regs_test;
	// clock, reset and engine strobes
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic guard_n = 1'b1;
	logic clk_en = 1'b1; // dropped once to show that a gated clock freezes the block
	logic op_start = 1'b0, op_done = 1'b0, sus_req = 1'b0, res_req = 1'b0, soft_rst = 1'b0;
	// link wires and observed outputs
	wire sck, cs_n, mosi, miso, miso_oe;
	logic busy, latch, paused, low_end, granule, invert, quad, wg_act, pause_act, rst_act, fast;
	logic [2:0] guard, otp;
	logic [1:0] drive;
	logic [7:0] rd;
	int num_errors = 0;
	int check_count = 0;
	// 4 ns system clock
	always #2 ref_clk = ~ref_clk;
	spi_host host (.SCK(sck), .CS_N(cs_n), .MOSI(mosi), .MISO(miso));
	// every input is driven by the bench or the host model
	flash_status_regs uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
		.SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso),
		.SPI_MISO_OE(miso_oe), .WRITE_GUARD_N(guard_n), .OP_START(op_start),
		.OP_DONE(op_done), .SUSPEND_REQ(sus_req), .RESUME_REQ(res_req),
		.SOFT_RESET(soft_rst), .BUSY(busy), .WRITE_LATCH_OPEN(latch),
		.PAUSED_OPERATION_FLAG(paused), .BLOCK_GUARD(guard), .PROTECT_FROM_LOW_END(low_end),
		.GRANULE_SIZE_SELECT(granule), .INVERT_PROTECT_MAP(invert), .OTP_LOCK(otp),
		.QUAD_IO_ENABLE(quad), .WRITE_GUARD_ACTIVE(wg_act), .PAUSE_PIN_ACTIVE(pause_act),
		.RESET_PIN_ACTIVE(rst_act), .DRIVE_LEVEL(drive), .FAST_READ_PRECHARGE_ENABLE(fast));
	// one cycle strobe, then time for the registered outputs to land
	`define PULSE(s) @(posedge ref_clk) s <= 1'b1; @(posedge ref_clk) s <= 1'b0; \
		repeat (4) @(posedge ref_clk);
	// verdict, the single exit point
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// read one status byte and compare
	task automatic rdr(input logic [7:0] cmd, input logic [7:0] exp);
		host.xfer({cmd, 16'h0000}, 2, rd);
		`CHK("status read", exp, rd)
	endtask
	// single byte command
	task automatic cmd1(input logic [7:0] c);
		host.xfer({c, 16'h0000}, 1, rd);
	endtask
	// enable frame, then write frame
	task automatic wr(input logic [7:0] en, input logic [23:0] fr, input int nb);
		cmd1(en);
		host.xfer(fr, nb, rd);
	endtask
	// bounded wait for the busy flag to drop
	task automatic idle();
		int i;
		for (i = 0; i < 3000 && busy !== 1'b0; i++) begin
			@(posedge ref_clk);
		end
		if (i == 3000) begin
			$display("CHECK FAILED busy wait expected 0 seen 1");
			num_errors++;
			end_of_test();
		end
	endtask
	task automatic t_reset();
		// output enable must rise for the data byte and fall at deselect
		fork
			rdr(flash_status_pkg::CMD_READ_FIRST, 8'h00);
			begin
				repeat (150) @(posedge ref_clk);
				`CHK("miso enable", 1'b1, miso_oe)
			end
		join
		`CHK("miso enable idle", 1'b0, miso_oe)
		rdr(flash_status_pkg::CMD_READ_SECOND, 8'h00);
		rdr(flash_status_pkg::CMD_READ_THIRD, 8'h00);
		`CHK("guard pin active", 1'b1, wg_act)
		`CHK("pause pin active", 1'b1, pause_act)
		$display("done reset values");
	endtask
	task automatic t_volatile();
		wr(8'h50, {flash_status_pkg::CMD_WRITE_FIRST, 8'h7C, 8'h46}, 3);
		rdr(flash_status_pkg::CMD_READ_FIRST, 8'h7C);
		rdr(flash_status_pkg::CMD_READ_SECOND, 8'h42);
		`CHK("block guard", 3'h7, guard)
		`CHK("low end", 1'b1, low_end)
		`CHK("granule", 1'b1, granule)
		`CHK("invert map", 1'b1, invert)
		`CHK("quad", 1'b1, quad)
		`CHK("guard pin active", 1'b0, wg_act)
		// no enable before this write, so it must be dropped
		host.xfer({flash_status_pkg::CMD_WRITE_FIRST, 16'h0000}, 3, rd);
		rdr(flash_status_pkg::CMD_READ_FIRST, 8'h7C);
		$display("done volatile write");
	endtask
	task automatic t_third();
		wr(8'h50, {flash_status_pkg::CMD_WRITE_THIRD, 8'hFF, 8'h00}, 2);
		rdr(flash_status_pkg::CMD_READ_THIRD, 8'hF0);
		`CHK("drive level", 2'h3, drive)
		`CHK("fast read", 1'b1, fast)
		`CHK("reset pin active", 1'b0, rst_act)
		wr(8'h50, {flash_status_pkg::CMD_WRITE_SECOND, 16'h0000}, 2);
		`CHK("reset pin active", 1'b1, rst_act)
		`CHK("pause pin active", 1'b0, pause_act)
		`CHK("guard pin active", 1'b1, wg_act)
		$display("done third register");
	endtask
	task automatic t_nv_write();
		cmd1(flash_status_pkg::CMD_WRITE_ENABLE);
		`CHK("latch", 1'b1, latch)
		host.xfer({flash_status_pkg::CMD_WRITE_FIRST, 8'h0F, 8'h00}, 2, rd);
		`CHK("busy", 1'b1, busy)
		// a disable while busy is ignored
		cmd1(flash_status_pkg::CMD_WRITE_DISABLE);
		`CHK("latch", 1'b1, latch)
		rdr(flash_status_pkg::CMD_READ_FIRST, 8'h0F);
		idle();
		`CHK("latch", 1'b0, latch)
		rdr(flash_status_pkg::CMD_READ_FIRST, 8'h0C);
		$display("done nonvolatile write");
	endtask
	task automatic t_soft();
		`PULSE(soft_rst)
		rdr(flash_status_pkg::CMD_READ_FIRST, 8'h0C);
		rdr(flash_status_pkg::CMD_READ_THIRD, 8'h00);
		`CHK("quad", 1'b0, quad)
		cmd1(flash_status_pkg::CMD_WRITE_ENABLE);
		cmd1(flash_status_pkg::CMD_WRITE_DISABLE);
		`CHK("latch", 1'b0, latch)
		// a frame sent while the clock is gated must leave no trace
		@(posedge ref_clk) clk_en <= 1'b0;
		cmd1(flash_status_pkg::CMD_WRITE_ENABLE);
		@(posedge ref_clk) clk_en <= 1'b1;
		repeat (4) @(posedge ref_clk);
		`CHK("latch while gated", 1'b0, latch)
		$display("done soft reset and disable");
	endtask
	task automatic t_protect();
		wr(8'h50, {flash_status_pkg::CMD_WRITE_FIRST, 8'h80, 8'h00}, 2);
		@(posedge ref_clk) guard_n <= 1'b0;
		wr(8'h50, {flash_status_pkg::CMD_WRITE_FIRST, 8'h84, 8'h00}, 2);
		rdr(flash_status_pkg::CMD_READ_FIRST, 8'h80);
		@(posedge ref_clk) guard_n <= 1'b1;
		wr(8'h50, {flash_status_pkg::CMD_WRITE_FIRST, 16'h0000}, 2);
		rdr(flash_status_pkg::CMD_READ_FIRST, 8'h00);
		// upper mode bit locks without the pin; a soft reset lifts the volatile lock
		wr(8'h50, {flash_status_pkg::CMD_WRITE_SECOND, 8'h01, 8'h00}, 2);
		wr(8'h50, {flash_status_pkg::CMD_WRITE_FIRST, 8'h1C, 8'h00}, 2);
		rdr(flash_status_pkg::CMD_READ_FIRST, 8'h00);
		`PULSE(soft_rst)
		wr(8'h50, {flash_status_pkg::CMD_WRITE_FIRST, 8'h1C, 8'h00}, 2);
		rdr(flash_status_pkg::CMD_READ_FIRST, 8'h1C);
		$display("done guard protection");
	endtask
	task automatic t_otp();
		wr(8'h06, {flash_status_pkg::CMD_WRITE_SECOND, 8'h08, 8'h00}, 2);
		idle();
		`CHK("otp lock", 3'h1, otp)
		rdr(flash_status_pkg::CMD_READ_SECOND, 8'h08);
		$display("done lock flags");
	endtask
	task automatic t_suspend();
		cmd1(flash_status_pkg::CMD_WRITE_ENABLE);
		`PULSE(op_start)
		`CHK("busy", 1'b1, busy)
		`PULSE(sus_req)
		`CHK("paused", 1'b1, paused)
		`CHK("busy", 1'b0, busy)
		rdr(flash_status_pkg::CMD_READ_SECOND, 8'h88);
		`PULSE(res_req)
		`CHK("paused", 1'b0, paused)
		`CHK("busy", 1'b1, busy)
		`PULSE(op_done)
		`CHK("busy", 1'b0, busy)
		`CHK("latch", 1'b0, latch)
		$display("done suspend and resume");
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		t_reset();
		t_volatile();
		t_third();
		t_nv_write();
		t_soft();
		t_protect();
		t_otp();
		t_suspend();
		end_of_test();
	end
endmodule
